//--- hw/tcoc_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// R01: a nonzero action field puts that channel's wave on its pin.
// R02: a pin's driver is enabled only by its direction bit.
// R03: without the modulator, channel b needs port data bit two set.
// R04: action fields are read per mode class: non-pwm, fast, phase correct.
// R05: non-pwm codes: 0 off, 1 toggle, 2 clear, 3 set on match.
// R06: fast code 1 toggles channel a only in modes 14 and 15, else off.
// R07: fast code 2 clears on match and sets at bottom.
// R08: fast code 3 sets on match and clears at bottom.
// R09: fast pwm ignores a match at top when the field's upper bit is set.
// R10: phase code 1 toggles channel a only in modes 9 and 11, else off.
// R11: phase code 2 clears on an up match and sets on a down match.
// R12: phase code 3 sets on an up match and clears on a down match.
// R13: the four mode bits choose count sequence, top source and waveform.
// R14: plain, clear-on-match and three pwm families are all supported.
// R15: upper mode bits live at bits 4 and 3 of the second control register.
// R16: bits 3 and 2 of the first control register read zero, writes dropped.
module tcoc_ctrl (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // counter state from the timer core
    input  wire logic        cnt_tick,
    input  wire logic [15:0] cnt_value,
    input  wire logic [15:0] cnt_top,
    input  wire logic        cnt_up,
    input  wire logic [15:0] chan_a_match_value,
    input  wire logic [15:0] chan_b_match_value,
    // mode seen by the timer core
    output logic [3:0]       waveform_mode_sel,
    // port logic
    input  wire logic        port_ddr_a,
    input  wire logic        port_ddr_b,
    input  wire logic        port_out_a,
    input  wire logic        port_out_b,
    input  wire logic        port_data_bit_two,
    input  wire logic        modulator_en,
    // pins
    output logic             pin_a_out,
    output logic             pin_a_oe,
    output logic             pin_b_out,
    output logic             pin_b_oe,
    output logic             chan_a_wave_out,
    output logic             chan_b_wave_out
);
    typedef enum logic {ph_idle, ph_write} tcoc_phase_t;

    typedef struct packed {
        tcoc_phase_t ph;
        logic [7:0]  wr_idx;
        logic [7:0]  outctl;
        logic [7:0]  clkctl;
        logic [31:0] rdata;
    } tcoc_state_t;

    tcoc_state_t         st;
    tcoc_state_t         next_st;
    logic                accept;
    logic                addr_ok;
    logic [7:0]          addr_idx;
    logic [7:0]          rd_byte;
    logic [7:0]          hw_byte;
    logic [7:0]          status;
    logic [1:0]          act_a;
    logic [1:0]          act_b;
    tcoc_pkg::tcoc_cls_t mode_cls;
    logic                bottom_hit;
    logic                hit_a;
    logic                hit_b;
    logic                top_a;
    logic                top_b;
    logic                link_a;
    logic                link_b;
    logic                wave_a;
    logic                wave_b;
    logic                b_gate;

    // bus decode; only word transfers are expected, lanes are not split
    assign accept   = hsel && hready && htrans[1];
    assign addr_idx = haddr[tcoc_pkg::IDX_MSB:tcoc_pkg::IDX_LSB];
    assign addr_ok  = haddr[31:tcoc_pkg::IDX_MSB+1] == '0;
    assign hw_byte  = hwdata[7:0];

    // fields of the control registers
    assign act_a = st.outctl[tcoc_pkg::ACT_A_LSB +: 2];
    assign act_b = st.outctl[tcoc_pkg::ACT_B_LSB +: 2];
    // mode is the upper pair from the second register over the lower pair
    assign waveform_mode_sel = {st.clkctl[tcoc_pkg::MODE_HI_LSB +: 2], // R15
                                st.outctl[tcoc_pkg::MODE_LO_LSB +: 2]};
    // the mode class steers both channel wave units; the core sees only the mode
    assign mode_cls = tcoc_pkg::mode_class(waveform_mode_sel); // R13 R14

    // status view of the block's own outputs
    always_comb begin
        status = '0;
        status[tcoc_pkg::ST_WAVE_A] = wave_a;
        status[tcoc_pkg::ST_WAVE_B] = wave_b;
        status[tcoc_pkg::ST_LINK_A] = link_a;
        status[tcoc_pkg::ST_LINK_B] = link_b;
    end

    // register file: write lands in the data phase, read is captured at
    // the address phase from the updated copy so a read right after a
    // write to the same register already sees the new value
    always_comb begin
        next_st = st;
        rd_byte = '0;
        if (st.ph == ph_write) begin
            case (st.wr_idx)
                tcoc_pkg::OUTCTL_IDX:
                    next_st.outctl = hw_byte & tcoc_pkg::OUTCTL_WMASK; // R16
                tcoc_pkg::CLKCTL_IDX:
                    next_st.clkctl = hw_byte & tcoc_pkg::CLKCTL_WMASK;
                default: next_st.outctl = st.outctl;
            endcase
        end
        next_st.ph = ph_idle;
        if (accept && hwrite) begin
            next_st.ph     = ph_write;
            next_st.wr_idx = addr_ok ? addr_idx : tcoc_pkg::NO_IDX;
        end else if (accept) begin
            case (addr_ok ? addr_idx : tcoc_pkg::NO_IDX)
                tcoc_pkg::OUTCTL_IDX: rd_byte = next_st.outctl;
                tcoc_pkg::CLKCTL_IDX: rd_byte = next_st.clkctl;
                tcoc_pkg::STATUS_IDX: rd_byte = status;
                default:              rd_byte = '0;
            endcase
            next_st.rdata = {24'h000000, rd_byte};
        end
    end

    // state register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st        <= '0;
            st.outctl <= tcoc_pkg::OUTCTL_RST;
            st.clkctl <= tcoc_pkg::CLKCTL_RST;
        end else begin
            st <= next_st;
        end
    end

    // zero-wait slave, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st.rdata;

    // compare events; match and bottom hits are qualified by the timer tick, top flags are not
    assign bottom_hit = cnt_tick && cnt_value == tcoc_pkg::CNT_BOTTOM;
    assign hit_a      = cnt_tick && cnt_value == chan_a_match_value;
    assign hit_b      = cnt_tick && cnt_value == chan_b_match_value;
    assign top_a      = chan_a_match_value == cnt_top;
    assign top_b      = chan_b_match_value == cnt_top;

    // channel a wave unit
    tcoc_chan #(
        .IS_A(1'b1)
    ) u_chan_a (
        .mclk         (mclk),
        .rstn         (rstn),
        .action       (act_a),
        .mode         (waveform_mode_sel),
        .mode_cls     (mode_cls),
        .match_hit    (hit_a),
        .bottom_hit   (bottom_hit),
        .match_at_top (top_a),
        .count_up     (cnt_up),
        .wave         (wave_a),
        .linked       (link_a)
    );

    // channel b wave unit
    tcoc_chan #(
        .IS_A(1'b0)
    ) u_chan_b (
        .mclk         (mclk),
        .rstn         (rstn),
        .action       (act_b),
        .mode         (waveform_mode_sel),
        .mode_cls     (mode_cls),
        .match_hit    (hit_b),
        .bottom_hit   (bottom_hit),
        .match_at_top (top_b),
        .count_up     (cnt_up),
        .wave         (wave_b),
        .linked       (link_b)
    );

    // pin muxing: a linked channel overrides port data but never the
    // direction bit, so software must still set the pin as an output
    assign b_gate    = modulator_en || port_data_bit_two; // R03
    assign pin_a_out = link_a ? wave_a : port_out_a; // R01
    assign pin_b_out = link_b ? (wave_b && b_gate) : port_out_b; // R01
    assign pin_a_oe  = port_ddr_a; // R02
    assign pin_b_oe  = port_ddr_b; // R02
    assign chan_a_wave_out = wave_a;
    assign chan_b_wave_out = wave_b;

    a_pin_release_a: assert property (@(posedge mclk) // R01
        disable iff (!rstn)
        act_a == tcoc_pkg::ACT_OFF |-> pin_a_out == port_out_a)
        else $error("channel a held the pin while its field is zero");
    a_pin_take_b: assert property (@(posedge mclk) disable iff (!rstn) // R01
        link_b && modulator_en |-> pin_b_out == chan_b_wave_out)
        else $error("channel b wave not on its pin");
    a_driver_ddr: assert property (@(posedge mclk) disable iff (!rstn) // R02
        pin_a_oe == port_ddr_a && pin_b_oe == port_ddr_b)
        else $error("pin driver not following direction bit");
    a_b_data_gate: assert property (@(posedge mclk) disable iff (!rstn) // R03
        link_b && !modulator_en && !port_data_bit_two |-> !pin_b_out)
        else $error("channel b drove high without data bit two");
    a_mode_join: assert property (@(posedge mclk) disable iff (!rstn) // R15
        st.ph == ph_write && st.wr_idx == tcoc_pkg::CLKCTL_IDX |=>
        waveform_mode_sel[3:2] == $past(hw_byte[4:3]))
        else $error("upper mode bits not taken from bits 4 and 3");
    a_reserved_zero: assert property (@(posedge mclk) // R16
        disable iff (!rstn)
        st.ph == ph_write && st.wr_idx == tcoc_pkg::OUTCTL_IDX |=>
        st.outctl == ($past(hw_byte) & tcoc_pkg::OUTCTL_WMASK))
        else $error("control write did not land with reserved bits zero");
    a_read_lands: assert property (@(posedge mclk) disable iff (!rstn) // R16
        accept && !hwrite && addr_ok &&
        addr_idx == tcoc_pkg::OUTCTL_IDX && st.ph == ph_idle |=>
        hrdata[3:2] == 2'b00 && hrdata[7:4] == $past(st.outctl[7:4]))
        else $error("control readback wrong");
endmodule
`default_nettype wire

//--- hw/tcoc_pkg.sv
`default_nettype none
package tcoc_pkg;
    // register indices; the bus byte address is four times the index
    localparam logic [7:0] OUTCTL_IDX   = 8'ha0;
    localparam logic [7:0] CLKCTL_IDX   = 8'ha1;
    localparam logic [7:0] STATUS_IDX   = 8'ha2;
    localparam logic [7:0] NO_IDX       = 8'h00;
    localparam int         IDX_LSB      = 2;
    localparam int         IDX_MSB      = 9;

    // reset values and writable-bit masks
    localparam logic [7:0] OUTCTL_RST   = 8'h00;
    localparam logic [7:0] CLKCTL_RST   = 8'h00;
    localparam logic [7:0] OUTCTL_WMASK = 8'hf3;
    localparam logic [7:0] CLKCTL_WMASK = 8'hdf;

    // field positions
    localparam int ACT_A_LSB   = 6;
    localparam int ACT_B_LSB   = 4;
    localparam int MODE_LO_LSB = 0;
    localparam int MODE_HI_LSB = 3;
    localparam int ST_WAVE_A   = 0;
    localparam int ST_WAVE_B   = 1;
    localparam int ST_LINK_A   = 2;
    localparam int ST_LINK_B   = 3;

    // output action field codes
    localparam logic [1:0] ACT_OFF    = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_SET    = 2'h3;

    // modes in which channel a may toggle under a pwm class
    localparam logic [3:0] MODE_FAST_ICR = 4'he;
    localparam logic [3:0] MODE_FAST_OCR = 4'hf;
    localparam logic [3:0] MODE_PFC_OCR  = 4'h9;
    localparam logic [3:0] MODE_PC_OCR   = 4'hb;

    localparam logic [15:0] CNT_BOTTOM = 16'h0000;

    typedef enum logic [1:0] {cls_nonpwm, cls_fast, cls_phase} tcoc_cls_t;

    // reserved mode 13 falls into the non-pwm set
    function automatic tcoc_cls_t mode_class(input logic [3:0] m);
        case (m)
            4'h5, 4'h6, 4'h7, 4'he, 4'hf: mode_class = cls_fast;
            4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: mode_class = cls_phase;
            default: mode_class = cls_nonpwm;
        endcase
    endfunction
endpackage
`default_nettype wire

//--- hw/tcoc_chan.sv
`timescale 1ns/10ps
`default_nettype none
module tcoc_chan #(
    parameter bit IS_A = 1'b0
) (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               rstn,
    // settings
    input  wire logic [1:0]         action,
    input  wire logic [3:0]         mode,
    input  wire tcoc_pkg::tcoc_cls_t mode_cls,
    // counter events; the match and bottom hits are already qualified by the timer tick
    input  wire logic               match_hit,
    input  wire logic               bottom_hit,
    input  wire logic               match_at_top,
    input  wire logic               count_up,
    // result
    output logic                    wave,
    output logic                    linked
);
    typedef struct packed {
        logic wave;
    } tcoc_chan_state_t;

    tcoc_chan_state_t st;
    tcoc_chan_state_t next_st;
    logic             toggle_ok;
    logic             match_live;

    // toggle is a channel-a privilege in pwm modes, free in non-pwm
    always_comb begin
        toggle_ok = 1'b0;
        case (mode_cls)
            tcoc_pkg::cls_fast: toggle_ok = IS_A && // R06
                (mode == tcoc_pkg::MODE_FAST_ICR ||
                 mode == tcoc_pkg::MODE_FAST_OCR);
            tcoc_pkg::cls_phase: toggle_ok = IS_A && // R10
                (mode == tcoc_pkg::MODE_PFC_OCR ||
                 mode == tcoc_pkg::MODE_PC_OCR);
            default: toggle_ok = 1'b1;
        endcase
    end

    // a toggle code without the privilege leaves the pin disconnected
    assign linked = action != tcoc_pkg::ACT_OFF && // R05
                    (action != tcoc_pkg::ACT_TOGGLE || toggle_ok);
    // in fast pwm, compare value at top with a set/clear code drops the match
    assign match_live = match_hit &&
        !(mode_cls == tcoc_pkg::cls_fast && match_at_top && action[1]); // R09

    // wave update; in fast pwm the bottom action is applied last and wins
    always_comb begin
        next_st = st;
        case (mode_cls) // R04
            tcoc_pkg::cls_fast: begin
                if (match_live) begin
                    case (action)
                        tcoc_pkg::ACT_TOGGLE: next_st.wave ^= toggle_ok;
                        tcoc_pkg::ACT_CLEAR:  next_st.wave = 1'b0; // R07
                        tcoc_pkg::ACT_SET:    next_st.wave = 1'b1; // R08
                        default:              next_st.wave = st.wave;
                    endcase
                end
                if (bottom_hit && action == tcoc_pkg::ACT_CLEAR) begin
                    next_st.wave = 1'b1; // R07
                end else if (bottom_hit && action == tcoc_pkg::ACT_SET) begin
                    next_st.wave = 1'b0; // R08
                end
            end
            tcoc_pkg::cls_phase: begin
                if (match_live) begin
                    case (action)
                        tcoc_pkg::ACT_TOGGLE: next_st.wave ^= toggle_ok;
                        tcoc_pkg::ACT_CLEAR:  next_st.wave = !count_up; // R11
                        tcoc_pkg::ACT_SET:    next_st.wave = count_up; // R12
                        default:              next_st.wave = st.wave;
                    endcase
                end
            end
            default: begin
                if (match_live) begin
                    case (action)
                        tcoc_pkg::ACT_TOGGLE: next_st.wave = ~st.wave; // R05
                        tcoc_pkg::ACT_CLEAR:  next_st.wave = 1'b0; // R05
                        tcoc_pkg::ACT_SET:    next_st.wave = 1'b1; // R05
                        default:              next_st.wave = st.wave;
                    endcase
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wave = st.wave;

    a_fast_bottom_set: assert property (@(posedge mclk) // R07
        disable iff (!rstn)
        mode_cls == tcoc_pkg::cls_fast && bottom_hit &&
        action == tcoc_pkg::ACT_CLEAR |=> wave == 1'b1)
        else $error("fast pwm clear code did not set at bottom");
    a_fast_inv_match: assert property (@(posedge mclk) // R08
        disable iff (!rstn)
        mode_cls == tcoc_pkg::cls_fast && match_hit && !bottom_hit &&
        !match_at_top && action == tcoc_pkg::ACT_SET |=> wave == 1'b1)
        else $error("fast pwm set code did not set on match");
    a_top_match_ignored: assert property (@(posedge mclk) // R09
        disable iff (!rstn)
        mode_cls == tcoc_pkg::cls_fast && match_hit && match_at_top &&
        action[1] && !bottom_hit |=> $stable(wave))
        else $error("match at top was not ignored");
    a_phase_up_down: assert property (@(posedge mclk) // R11
        disable iff (!rstn)
        mode_cls == tcoc_pkg::cls_phase && match_hit &&
        action == tcoc_pkg::ACT_CLEAR |=> wave == !$past(count_up))
        else $error("phase pwm clear code wrong for count direction");
    a_toggle_blocked: assert property (@(posedge mclk) // R06
        disable iff (!rstn)
        action == tcoc_pkg::ACT_TOGGLE && !linked |=> $stable(wave))
        else $error("disconnected toggle code changed the wave");
endmodule
`default_nettype wire

//--- verif/tcoc_pad.sv
`timescale 1ns/10ps
`default_nettype none
// pad model of the two shared pins; an undriven pad floats to its pull-up
module tcoc_pad (
    // pin drive from the block
    input  wire logic pin_a_out,
    input  wire logic pin_a_oe,
    input  wire logic pin_b_out,
    input  wire logic pin_b_oe,
    // resolved pad levels
    output logic      pad_a,
    output logic      pad_b
);
    // pull-up keeps a released pad from echoing the last driven value
    assign pad_a = pin_a_oe ? pin_a_out : 1'b1;
    assign pad_b = pin_b_oe ? pin_b_out : 1'b1;
endmodule
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define TCOCTB_CMP(o, e) \
    if ((o) !== (e)) begin \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, o, e); \
        mismatches++; \
    end \
    comparisons++;
module testbench;
    typedef struct packed {logic [1:0] kind; logic [31:0] v;} tcoctb_note_t;
    typedef struct packed {
        logic [3:0] m; logic [1:0] a; logic [1:0] b;
        logic [15:0] v; logic up; logic top;
    } tcoctb_ent_t;
    localparam logic [15:0] MV = 16'h0040;
    localparam logic [31:0] A_OUT = {22'h0, tcoc_pkg::OUTCTL_IDX, 2'h0};
    localparam logic [31:0] A_CLK = {22'h0, tcoc_pkg::CLKCTL_IDX, 2'h0};
    localparam logic [31:0] A_ST  = {22'h0, tcoc_pkg::STATUS_IDX, 2'h0};
    localparam logic [31:0] A_NO  = 32'h0000_0300;
    localparam int N = 22;
    // each row: mode, action a, action b, counter value, up, match at top
    localparam tcoctb_ent_t tab [0:N-1] = '{
        '{4'h0,2'h1,2'h1,MV,1'b1,1'b0}, '{4'h0,2'h1,2'h1,MV,1'b1,1'b0},
        '{4'h0,2'h3,2'h2,MV,1'b1,1'b0}, '{4'h0,2'h2,2'h3,MV,1'b1,1'b0},
        '{4'h0,2'h0,2'h0,MV,1'b1,1'b0}, '{4'h4,2'h1,2'h3,MV,1'b0,1'b0},
        '{4'hc,2'h3,2'h1,MV,1'b1,1'b0}, '{4'he,2'h2,2'h2,MV,1'b1,1'b0},
        '{4'he,2'h2,2'h3,16'h0,1'b1,1'b0}, '{4'he,2'h3,2'h2,MV,1'b1,1'b0},
        '{4'he,2'h1,2'h1,MV,1'b1,1'b0}, '{4'hf,2'h1,2'h1,MV,1'b1,1'b0},
        '{4'h5,2'h1,2'h1,MV,1'b1,1'b0}, '{4'h7,2'h2,2'h3,16'h0,1'b1,1'b0},
        '{4'he,2'h3,2'h2,MV,1'b1,1'b1}, '{4'h6,2'h2,2'h3,16'h0,1'b1,1'b1},
        '{4'hb,2'h2,2'h2,MV,1'b1,1'b0}, '{4'hb,2'h2,2'h3,MV,1'b0,1'b0},
        '{4'h9,2'h1,2'h1,MV,1'b1,1'b0}, '{4'ha,2'h1,2'h1,MV,1'b0,1'b0},
        '{4'h8,2'h3,2'h3,MV,1'b1,1'b0}, '{4'h1,2'h3,2'h2,MV,1'b0,1'b0}};
    logic mclk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, look = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic cnt_tick = 1'b0, cnt_up = 1'b0, ddr_a = 1'b0, ddr_b = 1'b0;
    logic po_a = 1'b0, po_b = 1'b0, bit2 = 1'b0, mod_en = 1'b0;
    logic [15:0] cnt_value = 16'h0, cnt_top = 16'hffff;
    logic hreadyout, hresp, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
    logic pad_a, pad_b, wa, wb, la, lb, cwa, cwb;
    logic [31:0] hrdata;
    logic [3:0] waveform_mode_sel;
    int mismatches = 0, comparisons = 0;
    tcoctb_note_t notes [$];
    tcoctb_ent_t e;
    always #20 mclk = ~mclk;
    tcoc_ctrl u_dut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .cnt_tick(cnt_tick), .cnt_value(cnt_value),
        .cnt_top(cnt_top), .cnt_up(cnt_up), .chan_a_match_value(MV),
        .chan_b_match_value(MV), .waveform_mode_sel(waveform_mode_sel),
        .port_ddr_a(ddr_a), .port_ddr_b(ddr_b), .port_out_a(po_a),
        .port_out_b(po_b), .port_data_bit_two(bit2), .modulator_en(mod_en),
        .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out),
        .pin_b_oe(pin_b_oe), .chan_a_wave_out(cwa), .chan_b_wave_out(cwb));
    tcoc_pad u_pad (.pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
        .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .pad_a(pad_a),
        .pad_b(pad_b));
    // monitor: the oldest note is judged at the edge where look is seen high
    always @(posedge mclk) begin
        tcoctb_note_t n;
        logic [31:0] o;
        if (look) begin
            n = notes.pop_front();
            o = (n.kind == 2'h0) ? hrdata : (n.kind == 2'h1) ?
                {25'h0, hresp, cwb, cwa, pin_b_oe, pad_b, pin_a_oe, pad_a} :
                {28'h0, waveform_mode_sel};
            `TCOCTB_CMP(o, n.v)
        end
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // waits for hready at a rising edge, never longer than the bound
    task automatic hold();
        int i;
        i = 0;
        @(posedge mclk);
        while (hreadyout !== 1'b1 && i < 100) begin
            @(posedge mclk);
            i++;
        end
        if (i >= 100) begin
            mismatches++;
            conclude();
        end
    endtask
    // one single word transfer; a read notes its expected data
    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [7:0] d, input logic [31:0] x);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        hold();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        if (!w) begin
            notes.push_back(tcoctb_note_t'{2'h0, x});
            look <= 1'b1;
        end
        hold();
        look <= 1'b0;
    endtask
    task automatic peek(input logic [1:0] k, input logic [31:0] x);
        @(posedge mclk);
        notes.push_back(tcoctb_note_t'{k, x});
        look <= 1'b1;
        @(posedge mclk);
        look <= 1'b0;
    endtask
    task automatic tick(input logic [15:0] v, input logic u);
        @(posedge mclk);
        cnt_tick <= 1'b1;
        cnt_value <= v;
        cnt_up <= u;
        @(posedge mclk);
        cnt_tick <= 1'b0;
        cnt_value <= 16'($urandom); // idle values must cause nothing
    endtask
    // 0 non-pwm, 1 fast, 2 phase correct families
    function automatic logic [1:0] cls(input logic [3:0] m);
        case (m)
            4'h5, 4'h6, 4'h7, 4'he, 4'hf: cls = 2'h1;
            4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: cls = 2'h2;
            default: cls = 2'h0;
        endcase
    endfunction
    function automatic logic ok(input logic [3:0] m, input logic isa);
        ok = isa && ((cls(m) == 2'h1) ? (m == 4'he || m == 4'hf)
                                      : (m == 4'h9 || m == 4'hb));
    endfunction
    function automatic logic nxt(input logic w, input logic [1:0] c,
                                 input tcoctb_ent_t t, input logic isa);
        logic [1:0] k;
        logic hit;
        k = cls(t.m);
        hit = (t.v == MV);
        nxt = w;
        if (k == 2'h0 && hit)
            nxt = (c == 2'h1) ? ~w : (c == 2'h2) ? 1'b0 :
                  (c == 2'h3) ? 1'b1 : w;
        if (k != 2'h0 && hit && !(k == 2'h1 && t.top && c[1]))
            nxt = (c == 2'h1 && ok(t.m, isa)) ? ~w : (c == 2'h2) ?
                  (k == 2'h2 && !t.up) : (c == 2'h3) ? (k == 2'h1 || t.up) : w;
        if (k == 2'h1 && t.v == 16'h0 && c[1])
            nxt = (c == 2'h2);
    endfunction
    function automatic logic lnk(input logic [1:0] c, input logic [3:0] m,
                                 input logic isa);
        lnk = (c != 2'h0) && !(c == 2'h1 && cls(m) != 2'h0 && !ok(m, isa));
    endfunction
    initial begin
        void'($urandom(32'h1f4ae928));
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        bus(A_OUT, 1'b0, 8'h0, 32'h0);
        bus(A_CLK, 1'b0, 8'h0, 32'h0);
        bus(A_ST, 1'b0, 8'h0, 32'h0);
        bus(A_NO, 1'b0, 8'h0, 32'h0);
        bus(A_OUT, 1'b1, 8'hff, 32'h0);
        bus(A_CLK, 1'b1, 8'hff, 32'h0);
        bus(A_NO, 1'b1, 8'hff, 32'h0);
        bus(A_ST, 1'b1, 8'hff, 32'h0);
        bus(A_OUT, 1'b0, 8'h0, 32'h0000_00f3);
        bus(A_CLK, 1'b0, 8'h0, 32'h0000_00df);
        bus(A_NO, 1'b0, 8'h0, 32'h0);
        // both fields now hold code 3, so both channels own their pins
        bus(A_ST, 1'b0, 8'h0, 32'h0000_000c);
        peek(2'h2, 32'hf);
        wa = 1'b0;
        wb = 1'b0;
        for (int i = 0; i < N; i++) begin
            e = tab[i];
            bus(A_CLK, 1'b1, {3'h0, e.m[3:2], 3'h0}, 32'h0);
            bus(A_OUT, 1'b1, {e.a, e.b, 2'h0, e.m[1:0]}, 32'h0);
            peek(2'h2, {28'h0, e.m});
            {ddr_a, ddr_b, po_a, po_b, bit2, mod_en} <= 6'($urandom);
            cnt_top <= e.top ? MV : 16'hffff;
            tick(e.v, e.up);
            wa = nxt(wa, e.a, e, 1'b1);
            wb = nxt(wb, e.b, e, 1'b0);
            la = lnk(e.a, e.m, 1'b1);
            lb = lnk(e.b, e.m, 1'b0);
            bus(A_ST, 1'b0, 8'h0, {28'h0, lb, la, wb, wa});
            peek(2'h1, {25'h0, 1'b0, wb, wa, ddr_b,
                ddr_b ? (lb ? wb & (mod_en | bit2) : po_b) : 1'b1, ddr_a,
                ddr_a ? (la ? wa : po_a) : 1'b1});
        end
        // a second reset in mid-run clears both control registers again
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        bus(A_OUT, 1'b0, 8'h0, 32'h0);
        bus(A_CLK, 1'b0, 8'h0, 32'h0);
        bus(A_ST, 1'b0, 8'h0, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
